//--- rtl/spt_pkg.sv
// Shared constants and types for the partitioned coupled-memory SRAM.
package spt_pkg;

    // ****************************************************************
    // Geometry and encodings
    // ****************************************************************
    // Number of 16 KB banks in the 48 KB array.
    localparam int SPT_BANKS = 3;
    // Words of 32 bits in one 16 KB bank.
    localparam int SPT_BANK_WORDS = 4096;
    // Region size codes written by software for each coupled region.
    localparam logic [1:0] SPT_SIZE_0K = 2'h0;
    localparam logic [1:0] SPT_SIZE_16K = 2'h1;
    localparam logic [1:0] SPT_SIZE_32K = 2'h2;
    // Bank code meaning that no bank backs the address.
    localparam logic [1:0] SPT_BANK_NONE = 2'h3;
    // Decoded region codes.
    localparam logic [1:0] SPT_REG_INSTR = 2'h0;
    localparam logic [1:0] SPT_REG_DATA = 2'h1;
    localparam logic [1:0] SPT_REG_SHARED = 2'h2;
    localparam logic [1:0] SPT_REG_NONE = 2'h3;

    // ****************************************************************
    // System bus map (1 MB windows, selected by address bits 31:20)
    // ****************************************************************
    localparam logic [11:0] SPT_WIN_ZERO = 12'h000;
    localparam logic [11:0] SPT_WIN_INSTR = 12'h001;
    localparam logic [11:0] SPT_WIN_DATA = 12'h002;
    localparam logic [11:0] SPT_WIN_SHARED = 12'h003;
    // Bus master numbers of the core instruction and data masters.
    localparam logic [3:0] SPT_MST_CORE_I = 4'h0;
    localparam logic [3:0] SPT_MST_CORE_D = 4'h1;
    // Response codes of the bus.
    localparam logic SPT_RESP_OKAY = 1'b0;
    localparam logic SPT_RESP_ERROR = 1'b1;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Split configuration as held in the first bus-matrix function register.
    typedef struct packed {
        logic [1:0] instr_size;
        logic [1:0] data_size;
    } spt_split_t;
    // Reset split: both coupled regions empty, all banks shared.
    localparam spt_split_t SPT_SPLIT_RESET = '{instr_size: 2'h0, data_size: 2'h0};

    // Request on a core coupled-memory port; the address is the byte offset.
    typedef struct packed {
        logic req;
        logic write;
        logic [3:0] be;
        logic [14:0] addr;
        logic [31:0] wdata;
    } spt_tcm_req_t;

    // System bus transfer captured in its address phase.
    typedef struct packed {
        logic [1:0] bank;
        logic [11:0] word;
        logic write;
        logic [3:0] be;
    } spt_req_t;

endpackage

//--- rtl/spt_bank.sv
// One 16 KB single-port SRAM bank with byte lane write enables.
`timescale 1ns/1ps
module spt_bank (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [3:0] be_in,
    input wire logic [11:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out
);

    // Storage array of the bank.
    logic [31:0] mem [spt_pkg::SPT_BANK_WORDS];

    // Writes touch only the enabled byte lanes.
    always_ff @(posedge sys_clk_in) begin
        if (en_in && we_in) begin
            for (int i = 0; i < 4; i++) begin
                if (be_in[i]) begin
                    mem[addr_in][8*i +: 8] <= wdata_in[8*i +: 8];
                end
            end
        end
    end

    // Read data is registered and holds until the next read.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (en_in && !we_in) begin
            rdata_out <= mem[addr_in];
        end
    end

endmodule

//--- rtl/spt_sram.sv
// Partitioned 48 KB SRAM shared by the core coupled ports and the system bus.
`timescale 1ns/1ps
module spt_sram (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire spt_pkg::spt_split_t sram_split_config_reg_in,
    input wire logic remap_core_instr_in,
    input wire logic remap_core_data_in,
    input wire spt_pkg::spt_tcm_req_t instr_coupled_region_in,
    output logic [31:0] instr_coupled_region_rdata_out,
    output logic instr_coupled_region_err_out,
    input wire spt_pkg::spt_tcm_req_t data_coupled_region_in,
    output logic [31:0] data_coupled_region_rdata_out,
    output logic data_coupled_region_err_out,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [3:0] hmaster_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Returns the bank behind a 16 KB slot of a region, or none.
    function automatic logic [1:0] map_bank(input spt_pkg::spt_split_t s, input logic [1:0] region,
                                            input logic [1:0] idx);
        logic [1:0] isz;
        logic [1:0] dsz;
        logic used0;
        logic used1;
        logic [2:0] total;
        isz = s.instr_size;
        dsz = s.data_size;
        total = {1'b0, isz} + {1'b0, dsz};
        map_bank = spt_pkg::SPT_BANK_NONE;
        // illegal splits fall back to all shared
        if (isz > spt_pkg::SPT_SIZE_32K || dsz > spt_pkg::SPT_SIZE_32K || total > 3'h2) begin
            isz = spt_pkg::SPT_SIZE_0K;
            dsz = spt_pkg::SPT_SIZE_0K;
        end
        used0 = (isz != spt_pkg::SPT_SIZE_0K) || (dsz == spt_pkg::SPT_SIZE_32K);
        used1 = (dsz != spt_pkg::SPT_SIZE_0K) || (isz == spt_pkg::SPT_SIZE_32K);
        case (region)
            spt_pkg::SPT_REG_INSTR: begin
                if (idx < isz) begin
                    map_bank = (idx == 2'h0) ? 2'h0 : 2'h1;
                end
            end
            spt_pkg::SPT_REG_DATA: begin
                if (idx < dsz) begin
                    map_bank = (idx == 2'h0) ? 2'h1 : 2'h0;
                end
            end
            // shared slots take the free banks
            spt_pkg::SPT_REG_SHARED: begin
                if (idx == 2'h0) begin
                    map_bank = 2'h2;
                end else if (idx == 2'h1) begin
                    map_bank = !used1 ? 2'h1 : (!used0 ? 2'h0 : spt_pkg::SPT_BANK_NONE);
                end else if (idx == 2'h2 && !used0 && !used1) begin
                    map_bank = 2'h0;
                end
            end
            default: begin
                map_bank = spt_pkg::SPT_BANK_NONE;
            end
        endcase
    endfunction

    // Byte lanes of a transfer from its size and low address bits.
    function automatic logic [3:0] lanes(input logic [2:0] size, input logic [1:0] a);
        case (size)
            3'h0: lanes = 4'h1 << a;
            3'h1: lanes = a[1] ? 4'hC : 4'h3;
            default: lanes = 4'hF;
        endcase
    endfunction

    // ****************************************************************
    // Split configuration
    // ****************************************************************

    // Live split used by every decoder.
    spt_pkg::spt_split_t split_r;

    // split follows config register each cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            split_r <= spt_pkg::SPT_SPLIT_RESET;
        end else begin
            split_r <= sram_split_config_reg_in;
        end
    end

    // ****************************************************************
    // Coupled port decode
    // ****************************************************************

    // Banks addressed by the two coupled ports.
    logic [1:0] ibank;
    logic [1:0] dbank;
    // Coupled ports hitting a backed slot.
    logic ihit;
    logic dhit;

    // coupled ports never reach shared banks
    assign ibank = map_bank(split_r, spt_pkg::SPT_REG_INSTR, {1'b0, instr_coupled_region_in.addr[14]});
    assign dbank = map_bank(split_r, spt_pkg::SPT_REG_DATA, {1'b0, data_coupled_region_in.addr[14]});
    assign ihit = instr_coupled_region_in.req && (ibank != spt_pkg::SPT_BANK_NONE);
    assign dhit = data_coupled_region_in.req && (dbank != spt_pkg::SPT_BANK_NONE);

    // ****************************************************************
    // System bus decode
    // ****************************************************************

    // Region, validity and bank of the bus address phase.
    logic [1:0] hregion;
    logic [1:0] hbank;
    logic hok;
    // Transfer accepted in this cycle.
    logic haccept;

    // Window decode of the bus address.
    always_comb begin
        hregion = spt_pkg::SPT_REG_NONE;
        case (haddr_in[31:20])
            spt_pkg::SPT_WIN_INSTR: hregion = spt_pkg::SPT_REG_INSTR;
            spt_pkg::SPT_WIN_DATA: hregion = spt_pkg::SPT_REG_DATA;
            spt_pkg::SPT_WIN_SHARED: hregion = spt_pkg::SPT_REG_SHARED;
            // zero alias per remapped core master
            spt_pkg::SPT_WIN_ZERO: begin
                if ((hmaster_in == spt_pkg::SPT_MST_CORE_I && remap_core_instr_in) ||
                    (hmaster_in == spt_pkg::SPT_MST_CORE_D && remap_core_data_in)) begin
                    hregion = spt_pkg::SPT_REG_SHARED;
                end
            end
            default: hregion = spt_pkg::SPT_REG_NONE;
        endcase
    end

    assign hbank = map_bank(split_r, hregion, haddr_in[15:14]);
    // empty or unbacked window is refused
    assign hok = (hregion != spt_pkg::SPT_REG_NONE) && (haddr_in[19:16] == 4'h0) &&
                 (hbank != spt_pkg::SPT_BANK_NONE);
    // every active beat handled as a single transfer
    assign haccept = hsel_in && htrans_in[1] && hready_in && hreadyout_out;

    // ****************************************************************
    // System bus transfer sequencer
    // ****************************************************************

    // One-hot states of the bus sequencer.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ACCESS = 5'b00010,
        ST_DONE = 5'b00100,
        ST_ERR1 = 5'b01000,
        ST_ERR2 = 5'b10000
    } spt_state_t;

    spt_state_t state_r;
    spt_state_t state_nxt;
    // Captured transfer.
    spt_pkg::spt_req_t req_r;
    // Bus access goes to its bank this cycle.
    logic ahb_go;

    // Coupled ports win the bank; the bus waits one more cycle for each cycle they hold it.
    assign ahb_go = (state_r == ST_ACCESS) && !(ihit && ibank == req_r.bank) && !(dhit && dbank == req_r.bank);

    // Next state of the bus sequencer.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_ACCESS: state_nxt = ahb_go ? ST_DONE : ST_ACCESS;
            ST_ERR1: state_nxt = ST_ERR2;
            ST_IDLE, ST_DONE, ST_ERR2: begin
                if (haccept) begin
                    state_nxt = hok ? ST_ACCESS : ST_ERR1;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // State register of the bus sequencer.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // capture bank, word and byte lanes
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_r <= '0;
        end else if (haccept) begin
            req_r <= '{bank: hbank, word: haddr_in[13:2], write: hwrite_in,
                       be: lanes(hsize_in, haddr_in[1:0])};
        end
    end

    // two data-phase cycles on the bus, more while a coupled port holds the bus's bank
    assign hreadyout_out = (state_r == ST_IDLE) || (state_r == ST_DONE) || (state_r == ST_ERR2);
    assign hresp_out = (state_r == ST_ERR1) || (state_r == ST_ERR2) ? spt_pkg::SPT_RESP_ERROR
                                                                  : spt_pkg::SPT_RESP_OKAY;

    // ****************************************************************
    // Bank array and port steering
    // ****************************************************************

    // Per-bank port signals.
    logic [2:0] b_en;
    logic [2:0] b_we;
    logic [3:0] b_be [3];
    logic [11:0] b_addr [3];
    logic [31:0] b_wdata [3];
    logic [31:0] b_rdata [3];

    // Steering: instruction port, then data port, then the bus.
    always_comb begin
        for (int b = 0; b < spt_pkg::SPT_BANKS; b++) begin
            b_en[b] = 1'b0;
            b_we[b] = 1'b0;
            b_be[b] = 4'h0;
            b_addr[b] = 12'h000;
            b_wdata[b] = 32'h0000_0000;
            if (ihit && ibank == 2'(b)) begin
                b_en[b] = 1'b1;
                b_we[b] = instr_coupled_region_in.write;
                b_be[b] = instr_coupled_region_in.be;
                b_addr[b] = instr_coupled_region_in.addr[13:2];
                b_wdata[b] = instr_coupled_region_in.wdata;
            end else if (dhit && dbank == 2'(b)) begin
                b_en[b] = 1'b1;
                b_we[b] = data_coupled_region_in.write;
                b_be[b] = data_coupled_region_in.be;
                b_addr[b] = data_coupled_region_in.addr[13:2];
                b_wdata[b] = data_coupled_region_in.wdata;
            end else if (ahb_go && req_r.bank == 2'(b)) begin
                b_en[b] = 1'b1;
                b_we[b] = req_r.write;
                b_be[b] = req_r.be;
                b_addr[b] = req_r.word;
                b_wdata[b] = hwdata_in;
            end
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_bank
        spt_bank u_bank (
            .sys_clk_in(sys_clk_in),
            .reset_n_in(reset_n_in),
            .en_in(b_en[g]),
            .we_in(b_we[g]),
            .be_in(b_be[g]),
            .addr_in(b_addr[g]),
            .wdata_in(b_wdata[g]),
            .rdata_out(b_rdata[g])
        );
    end

    // Banks each coupled port used in its last hit, and their error flags.
    logic [1:0] ibank_r;
    logic [1:0] dbank_r;

    // coupled answers one cycle after request
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ibank_r <= 2'h0;
            dbank_r <= 2'h0;
            instr_coupled_region_err_out <= 1'b0;
            data_coupled_region_err_out <= 1'b0;
        end else begin
            ibank_r <= ihit ? ibank : ibank_r;
            dbank_r <= dhit ? dbank : dbank_r;
            instr_coupled_region_err_out <= instr_coupled_region_in.req && !ihit;
            data_coupled_region_err_out <= data_coupled_region_in.req && !dhit;
        end
    end

    // Read data comes straight from the bank output registers.
    assign instr_coupled_region_rdata_out = (ibank_r == 2'h3) ? 32'h0000_0000 : b_rdata[ibank_r];
    assign data_coupled_region_rdata_out = (dbank_r == 2'h3) ? 32'h0000_0000 : b_rdata[dbank_r];
    assign hrdata_out = (req_r.bank == 2'h3) ? 32'h0000_0000 : b_rdata[req_r.bank];

    // ****************************************************************
    // Assertions
    // ****************************************************************

    // Start of a refused bus transfer.
    sequence s_err_start;
        haccept && !hok;
    endsequence
    // Two-cycle error response.
    sequence s_err_resp;
        (hresp_out && !hreadyout_out) ##1 (hresp_out && hreadyout_out);
    endsequence

    a_err_two_cycle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_err_start |=> s_err_resp) else $error("error response not two cycles");
    a_err_no_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        s_err_start ##1 (!ihit && !dhit) |-> b_en == 3'b000) else $error("refused transfer reached a bank");
    a_bus_two_cycle: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (haccept && hok ##1 !ihit && !dhit) |-> !hreadyout_out ##1 (hreadyout_out && !hresp_out))
        else $error("bus access not two cycles");
    a_coupled_ok: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ihit |=> !instr_coupled_region_err_out) else $error("coupled access flagged");
    a_shared_kept: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (ibank != 2'h2) && (dbank != 2'h2)) else $error("bank 2 left shared region");
    a_shared_base: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        haccept && haddr_in[31:14] == 18'h00C0 |-> hok && hbank == 2'h2) else $error("shared base not bank 2");
    a_zero_remap: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        haccept && haddr_in[31:14] == 18'h0 && hmaster_in == 4'h0 && remap_core_instr_in |-> hbank == 2'h2)
        else $error("zero alias missing after remap");
    a_zero_before: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        haccept && haddr_in[31:20] == 12'h0 && !remap_core_instr_in && !remap_core_data_in |=> hresp_out)
        else $error("zero alias before remap");
    a_byte_lane: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        haccept && hsize_in == 3'h0 |=> $countones(req_r.be) == 1) else $error("byte write lanes wrong");
    a_split_follow: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        split_r == $past(sram_split_config_reg_in)) else $error("split not re-steered");

endmodule

//--- rtl/_unused_note.sv
// This file holds no logic of the block.

//--- verification/spt_ahb_model.sv
// Behavioural system bus master that issues single transfers to the SRAM.
`timescale 1ns/1ps
module spt_ahb_model (
    input wire logic sys_clk_in,
    input wire logic hreadyout_in,
    input wire logic hresp_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [3:0] hmaster_out,
    output logic [31:0] hwdata_out,
    output logic hready_out
);
    // The bus starts idle and this master never stretches a transfer itself.
    initial begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hmaster_out = 4'h0;
        hwdata_out = 32'h0;
        hready_out = 1'b1;
    end
    // Runs one transfer and reports the data-phase edges it took.
    task automatic xfer(input logic [3:0] mst, input logic [31:0] addr, input logic wr, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd, output logic resp, output int waits);
        @(posedge sys_clk_in);
        hsel_out <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out <= addr;
        hwrite_out <= wr;
        hsize_out <= sz;
        hmaster_out <= mst;
        @(posedge sys_clk_in);
        // The address lines are released to the inverse so stale values never look valid.
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        haddr_out <= ~addr;
        hwdata_out <= wd;
        waits = 0;
        do begin
            @(posedge sys_clk_in);
            waits = waits + 1;
        end while (hreadyout_in !== 1'b1 && waits < 20);
        rd = hrdata_in;
        resp = hresp_in;
        hwdata_out <= ~wd;
    endtask
endmodule

//--- verification/spt_sram_tb.sv
// Self-checking testbench for the partitioned SRAM.
`timescale 1ns/1ps
module spt_sram_tb;
    localparam logic OK = spt_pkg::SPT_RESP_OKAY;
    localparam logic ER = spt_pkg::SPT_RESP_ERROR;
    localparam logic [1:0] Z = spt_pkg::SPT_SIZE_0K;
    localparam logic [1:0] S16 = spt_pkg::SPT_SIZE_16K;
    localparam logic [1:0] S32 = spt_pkg::SPT_SIZE_32K;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    spt_pkg::spt_split_t split_cfg = spt_pkg::SPT_SPLIT_RESET;
    logic remap_i = 1'b0;
    logic remap_d = 1'b0;
    spt_pkg::spt_tcm_req_t instr_req = '0;
    spt_pkg::spt_tcm_req_t data_req = '0;
    logic [31:0] i_rd, d_rd, hrdata, haddr, hwdata;
    logic i_err, d_err, hreadyout, hresp, hsel, hwrite, hready;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] hmaster;
    int err_total = 0;
    int tests_run = 0;
    int cycle_cnt = 0;
    // The clock toggles every half period of 25 ns.
    always #25 sys_clk = ~sys_clk;
    spt_sram dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .sram_split_config_reg_in(split_cfg),
        .remap_core_instr_in(remap_i), .remap_core_data_in(remap_d), .instr_coupled_region_in(instr_req),
        .instr_coupled_region_rdata_out(i_rd), .instr_coupled_region_err_out(i_err),
        .data_coupled_region_in(data_req), .data_coupled_region_rdata_out(d_rd),
        .data_coupled_region_err_out(d_err), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hmaster_in(hmaster), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp));
    spt_ahb_model bus (.sys_clk_in(sys_clk), .hreadyout_in(hreadyout), .hresp_in(hresp), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hmaster_out(hmaster), .hwdata_out(hwdata), .hready_out(hready));
    // Prints the counts and the verdict, then stops the run.
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Compares one value and counts the outcome.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Runs one bus transfer and judges response, length and read data.
    task automatic bus_chk(input logic [3:0] mst, input logic [31:0] addr, input logic wr, input logic [2:0] sz,
                           input logic [31:0] wd, input logic exp_resp, input logic [31:0] exp_rd);
        logic [31:0] rd;
        logic resp;
        int waits;
        bus.xfer(mst, addr, wr, sz, wd, rd, resp, waits);
        check($sformatf("bus resp %h", addr), {31'h0, resp}, {31'h0, exp_resp});
        check($sformatf("bus cycles %h", addr), 32'(waits), 32'h2);
        if (!wr && exp_resp == OK) check($sformatf("bus data %h", addr), rd, exp_rd);
    endtask
    // Runs one coupled-port word access and judges the answer a cycle later.
    task automatic core_chk(input int port, input logic wr, input logic [14:0] addr, input logic [31:0] wd,
                            input logic exp_err, input logic [31:0] exp_rd);
        spt_pkg::spt_tcm_req_t rq;
        rq = '{req: 1'b1, write: wr, be: 4'hF, addr: addr, wdata: wd};
        @(posedge sys_clk);
        if (port == 0) instr_req <= rq; else data_req <= rq;
        @(posedge sys_clk);
        rq.req = 1'b0;
        rq.wdata = ~wd;
        if (port == 0) instr_req <= rq; else data_req <= rq;
        @(posedge sys_clk);
        check($sformatf("core%0d err %h", port, addr), {31'h0, port == 0 ? i_err : d_err}, {31'h0, exp_err});
        if (!wr && !exp_err) check($sformatf("core%0d data %h", port, addr), port == 0 ? i_rd : d_rd, exp_rd);
    endtask
    // Programs a new split and lets it settle.
    task automatic set_split(input logic [1:0] isz, input logic [1:0] dsz);
        @(posedge sys_clk);
        split_cfg <= '{instr_size: isz, data_size: dsz};
        repeat (2) @(posedge sys_clk);
    endtask
    // Reset state and the all-shared map with its empty windows.
    task automatic t_reset_map();
        check("idle ready", {31'h0, hreadyout}, 32'h1);
        bus_chk(4'h2, 32'h0030_0000, 1'b1, 3'h2, 32'hA2A2_0002, OK, 32'h0);
        bus_chk(4'h2, 32'h0030_4000, 1'b1, 3'h2, 32'hA1A1_0001, OK, 32'h0);
        bus_chk(4'h2, 32'h0030_8000, 1'b1, 3'h2, 32'hA0A0_0000, OK, 32'h0);
        bus_chk(4'h3, 32'h0030_0000, 1'b0, 3'h2, 32'h0, OK, 32'hA2A2_0002);
        bus_chk(4'h3, 32'h0030_8000, 1'b0, 3'h2, 32'h0, OK, 32'hA0A0_0000);
        bus_chk(4'h2, 32'h0010_0000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        bus_chk(4'h0, 32'h0000_0000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        core_chk(0, 1'b0, 15'h0000, 32'h0, 1'b1, 32'h0);
        $display("Test reset_map done");
    endtask
    // Narrow writes touch only their own byte lanes.
    task automatic t_widths();
        bus_chk(4'h2, 32'h0030_0004, 1'b1, 3'h2, 32'h1122_3344, OK, 32'h0);
        bus_chk(4'h2, 32'h0030_0005, 1'b1, 3'h0, 32'h0000_AA00, OK, 32'h0);
        bus_chk(4'h2, 32'h0030_0006, 1'b1, 3'h1, 32'hBEEF_0000, OK, 32'h0);
        bus_chk(4'h2, 32'h0030_0004, 1'b0, 3'h2, 32'h0, OK, 32'hBEEF_AA44);
        $display("Test widths done");
    endtask
    // Every legal split setting re-steers the banks between ports and windows; an illegal one falls back to all shared.
    task automatic t_split();
        set_split(S16, S16);
        core_chk(0, 1'b0, 15'h0000, 32'h0, 1'b0, 32'hA0A0_0000);
        core_chk(1, 1'b0, 15'h0000, 32'h0, 1'b0, 32'hA1A1_0001);
        core_chk(0, 1'b1, 15'h0000, 32'hB0B0_0000, 1'b0, 32'h0);
        bus_chk(4'h1, 32'h0010_0000, 1'b0, 3'h2, 32'h0, OK, 32'hB0B0_0000);
        bus_chk(4'h2, 32'h0020_0000, 1'b0, 3'h2, 32'h0, OK, 32'hA1A1_0001);
        bus_chk(4'h2, 32'h0030_4000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        bus_chk(4'h2, 32'h0030_8000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        bus_chk(4'h2, 32'h0030_0000, 1'b0, 3'h2, 32'h0, OK, 32'hA2A2_0002);
        core_chk(0, 1'b0, 15'h4000, 32'h0, 1'b1, 32'h0);
        bus_chk(4'h2, 32'h0010_4000, 1'b1, 3'h2, 32'hC1C1_0001, ER, 32'h0);
        set_split(S16, Z);
        bus_chk(4'h2, 32'h0030_4000, 1'b0, 3'h2, 32'h0, OK, 32'hA1A1_0001);
        core_chk(1, 1'b0, 15'h0000, 32'h0, 1'b1, 32'h0);
        bus_chk(4'h2, 32'h0020_0000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        set_split(Z, S16);
        bus_chk(4'h2, 32'h0030_4000, 1'b0, 3'h2, 32'h0, OK, 32'hB0B0_0000);
        set_split(S32, Z);
        core_chk(0, 1'b0, 15'h4000, 32'h0, 1'b0, 32'hA1A1_0001);
        set_split(Z, S32);
        core_chk(1, 1'b0, 15'h4000, 32'h0, 1'b0, 32'hB0B0_0000);
        set_split(S32, S16);
        bus_chk(4'h2, 32'h0030_8000, 1'b0, 3'h2, 32'h0, OK, 32'hB0B0_0000);
        set_split(Z, Z);
        $display("Test split done");
    endtask
    // A coupled read of the bus's bank in the bus access cycle wins; the bus waits one cycle.
    task automatic t_conflict();
        logic [31:0] rd;
        logic resp;
        int waits;
        set_split(S16, Z);
        fork
            bus.xfer(4'h2, 32'h0010_0000, 1'b0, 3'h2, 32'h0, rd, resp, waits);
            begin
                @(posedge sys_clk);
                core_chk(0, 1'b0, 15'h0000, 32'h0, 1'b0, 32'hB0B0_0000);
            end
        join
        check("conflict cycles", 32'(waits), 32'h3);
        check("conflict data", rd, 32'hB0B0_0000);
        set_split(Z, Z);
        $display("Test conflict done");
    endtask
    // The zero window opens per core master once its remap is done.
    task automatic t_remap();
        @(posedge sys_clk);
        remap_d <= 1'b1;
        bus_chk(4'h1, 32'h0000_0000, 1'b0, 3'h2, 32'h0, OK, 32'hA2A2_0002);
        bus_chk(4'h0, 32'h0000_0000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        bus_chk(4'h2, 32'h0000_0000, 1'b0, 3'h2, 32'h0, ER, 32'h0);
        @(posedge sys_clk);
        remap_i <= 1'b1;
        bus_chk(4'h0, 32'h0000_0004, 1'b0, 3'h2, 32'h0, OK, 32'hBEEF_AA44);
        $display("Test remap done");
    endtask
    // A hang is cut short well beyond the under two hundred cycles the tests need.
    always @(posedge sys_clk) begin
        cycle_cnt = cycle_cnt + 1;
        if (cycle_cnt == 3000) begin
            err_total = err_total + 1;
            close_out();
        end
    end
    // Main sequence: reset for four cycles, then each scenario in turn.
    initial begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset_map();
        t_widths();
        t_split();
        t_conflict();
        t_remap();
        close_out();
    end
endmodule
